// >>> mcsw_regs.vh
// Register offsets, field positions, codes and reset values of the check state word block.
`ifndef MCSW_REGS_VH
`define MCSW_REGS_VH
// ****************************************************************
// Register byte addresses on the AXI4-Lite bus.
// ****************************************************************
`define MCSW_WORD_LO_ADDR   8'h00
`define MCSW_WORD_HI_ADDR   8'h04
`define MCSW_CTRL_ADDR      8'h08
`define MCSW_EVENT_ADDR     8'h0c
`define MCSW_INFO_ADDR      8'h10
`define MCSW_ENTRY_ADDR     8'h14
`define MCSW_CAUSE_ADDR     8'h18
// ****************************************************************
// Field positions within the 64-bit state word.
// ****************************************************************
`define MCSW_PRECISE_IP_BIT 13
`define MCSW_EXACT_SAVE_BIT 14
`define MCSW_VOLATILE_BIT   15
`define MCSW_CAUSE_BIT      16
`define MCSW_RSTACK_BIT     17
`define MCSW_FIXED_BIT      18
`define MCSW_ANTICIP_BIT    19
`define MCSW_RES_LO_BIT     20
`define MCSW_GENERAL_BIT    31
`define MCSW_DSIZE_LO_BIT   32
`define MCSW_RSVD_LO_BIT    48
`define MCSW_CAT_LO_BIT     59
// ****************************************************************
// Entry reason codes for the platform firmware entry.
// ****************************************************************
`define MCSW_REASON_RESET   8'h00
`define MCSW_REASON_MCHECK  8'h01
`define MCSW_REASON_INIT    8'h02
`define MCSW_REASON_RECOVER 8'h03
// ****************************************************************
// Reset values.
// ****************************************************************
`define MCSW_WORD_RESET     64'h0000_0000_0000_0000
`define MCSW_CTRL_RESET     32'h0000_0000
`endif

// >>> mcsw_state_word.v
// Machine check and soft restart state word builder with an AXI4-Lite slave.
//
// What this block does
// - Bit 13 set only if faulting IP recorded.
// - Bit 14 for exact save; forces 13.
// - Bit 15 flags valid dynamic state.
// - Bit 16 cause: 0 check, 1 restart.
// - Bit 17 flags valid register stack state.
// - Bit 18 corrected; zero on restart.
// - Bit 19 expected; zero on restart.
// - Bits 20-30 flag eleven resource groups valid.
// - Bit 31 flags general registers, unbanked only.
// - Bits 47:32 hold dynamic state byte size.
// - Bits 59-63 error categories; zero on restart.
// - Restart loads defined values; others left open.
// - Entry parameter carries 8-bit reason field.
// - Reason codes 0..3 only; never reserved.
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "mcsw_regs.vh"

module mcsw_state_word #(
  parameter ADDR_W = 8                      // Width of the AXI4-Lite address.
) (
  input  wire              REF_CLK,
  input  wire              RESET_N,
  input  wire              EVT_MCHECK,
  input  wire              EVT_INIT,
  input  wire              EVT_RESET,
  input  wire              EVT_RECOVER,
  input  wire              PRECISE_IP_FLAG,
  input  wire              EXACT_SAVE_AREA_FLAG,
  input  wire              VOLATILE_STATE_OK,
  input  wire              REGISTER_STACK_OK,
  input  wire              ERROR_FIXED,
  input  wire              ANTICIPATED_ERROR,
  input  wire [10:0]       RESOURCE_OK,
  input  wire              GENERAL_REGS_OK,
  input  wire [15:0]       DSIZE_BYTES,
  input  wire [4:0]        FAULT_CATEGORY,
  output wire [63:0]       MACHINE_CHECK_STATE_WORD,
  output wire [7:0]        PLATFORM_FIRMWARE_ENTRY,
  output wire              WORD_VALID,
  input  wire [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire              S_AXI_AWVALID,
  output wire              S_AXI_AWREADY,
  input  wire [31:0]       S_AXI_WDATA,
  input  wire [3:0]        S_AXI_WSTRB,
  input  wire              S_AXI_WVALID,
  output wire              S_AXI_WREADY,
  output wire [1:0]        S_AXI_BRESP,
  output wire              S_AXI_BVALID,
  input  wire              S_AXI_BREADY,
  input  wire [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire              S_AXI_ARVALID,
  output wire              S_AXI_ARREADY,
  output wire [31:0]       S_AXI_RDATA,
  output wire [1:0]        S_AXI_RRESP,
  output wire              S_AXI_RVALID,
  input  wire              S_AXI_RREADY
);

  // ****************************************************************
  // Local definitions.
  // ****************************************************************
  localparam [1:0] RESP_OKAY   = 2'h0;      // Normal access answer.
  localparam [1:0] RESP_SLVERR = 2'h2;      // Unmapped address answer.

  reg [63:0]       word_q;                  // Assembled state word.
  reg [7:0]        reason_q;                // Last entry reason code.
  reg              valid_q;                 // Word holds a captured event.
  reg [31:0]       ctrl_q;                  // Software override control.
  reg [3:0]        cause_q;                 // Sticky record of seen events.
  reg [3:0]        cause_clr;               // Write-one-to-clear mask this cycle.
  reg              aw_full_q;               // Write address held.
  reg [ADDR_W-1:0] aw_addr_q;               // Held write address.
  reg              w_full_q;                // Write data held.
  reg [31:0]       w_data_q;                // Held write data.
  reg [3:0]        w_strb_q;                // Held write strobes.
  reg              b_valid_q;               // Write answer pending.
  reg [1:0]        b_resp_q;                // Write answer code.
  reg              r_valid_q;               // Read answer pending.
  reg [31:0]       r_data_q;                // Read answer data.
  reg [1:0]        r_resp_q;                // Read answer code.
  reg [63:0]       word_d;                  // Next state word.
  reg [7:0]        reason_d;                // Next reason code.
  wire             wr_go;                   // Address and data both held.
  wire             any_evt;                 // Some entry event this cycle.
  wire [3:0]       evt_vec;                 // Events in cause order.

  // Control bit 0 forces the check to be reported as corrected.
  // Control bit 1 masks recording of the faulting instruction pointer.
  wire             force_fixed = ctrl_q[0];
  wire             mask_ip     = ctrl_q[1];

  assign evt_vec = {EVT_RECOVER, EVT_INIT, EVT_MCHECK, EVT_RESET};
  assign any_evt = |evt_vec;

  // ****************************************************************
  // Byte-lane merge used by the control register.
  // ****************************************************************
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer      k;
    begin
      lane_merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          lane_merge[k*8 +: 8] = new_v[k*8 +: 8];
        end
      end
    end
  endfunction

  // ****************************************************************
  // Next state word and reason code.
  // ****************************************************************
  // Priority among same-cycle events: reset, then restart, then check,
  // then recovery check; a recovery check only updates the reason code.
  always @* begin
    word_d   = word_q;
    reason_d = reason_q;
    if (EVT_RESET) begin
      reason_d = `MCSW_REASON_RESET;
      word_d   = `MCSW_WORD_RESET;
    end else if (EVT_INIT) begin
      word_d = `MCSW_WORD_RESET;
      word_d[`MCSW_CAUSE_BIT] = 1'b1;
      // corrected starts clear, expected starts clear.
      word_d[`MCSW_FIXED_BIT]   = 1'b0;
      word_d[`MCSW_ANTICIP_BIT] = 1'b0;
      word_d[`MCSW_CAT_LO_BIT +: 5] = 5'h00;
      // Unspecified fields are taken from the handler's inputs, except bits 13 and 14, which stay zero.
      word_d[`MCSW_VOLATILE_BIT]    = VOLATILE_STATE_OK;
      word_d[`MCSW_RSTACK_BIT]      = REGISTER_STACK_OK;
      word_d[`MCSW_RES_LO_BIT +: 11] = RESOURCE_OK;
      word_d[`MCSW_GENERAL_BIT]     = GENERAL_REGS_OK;
      word_d[`MCSW_DSIZE_LO_BIT +: 16] = DSIZE_BYTES;
      reason_d = `MCSW_REASON_INIT;
    end else if (EVT_MCHECK) begin
      word_d = `MCSW_WORD_RESET;
      word_d[`MCSW_PRECISE_IP_BIT] = (PRECISE_IP_FLAG | EXACT_SAVE_AREA_FLAG) & ~mask_ip;
      word_d[`MCSW_EXACT_SAVE_BIT] = EXACT_SAVE_AREA_FLAG & ~mask_ip;
      word_d[`MCSW_VOLATILE_BIT]   = VOLATILE_STATE_OK;
      word_d[`MCSW_CAUSE_BIT]      = 1'b0;
      word_d[`MCSW_RSTACK_BIT]     = REGISTER_STACK_OK;
      word_d[`MCSW_FIXED_BIT]      = ERROR_FIXED | force_fixed;
      word_d[`MCSW_ANTICIP_BIT]    = ANTICIPATED_ERROR;
      word_d[`MCSW_RES_LO_BIT +: 11] = RESOURCE_OK;
      word_d[`MCSW_GENERAL_BIT]    = GENERAL_REGS_OK;
      word_d[`MCSW_DSIZE_LO_BIT +: 16] = DSIZE_BYTES;
      word_d[`MCSW_CAT_LO_BIT +: 5] = FAULT_CATEGORY;
      reason_d = `MCSW_REASON_MCHECK;
    end else if (EVT_RECOVER) begin
      reason_d = `MCSW_REASON_RECOVER;
    end
    word_d[`MCSW_RSVD_LO_BIT +: 11] = 11'h000;
    word_d[12:0] = 13'h0000;
  end

  // ****************************************************************
  // State word capture.
  // ****************************************************************
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      word_q   <= `MCSW_WORD_RESET;
      reason_q <= `MCSW_REASON_RESET;
      valid_q  <= 1'b0;
    end else begin
      word_q   <= word_d;
      reason_q <= reason_d;
      if (any_evt) begin
        valid_q <= 1'b1;
      end
    end
  end

  assign MACHINE_CHECK_STATE_WORD = word_q;
  assign PLATFORM_FIRMWARE_ENTRY  = reason_q;
  assign WORD_VALID               = valid_q;

  // ****************************************************************
  // Sticky cause record; a new event wins over a clear.
  // ****************************************************************
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cause_q <= 4'h0;
    end else begin
      cause_q <= (cause_q & ~cause_clr) | evt_vec;
    end
  end

  // ****************************************************************
  // AXI4-Lite write channel.
  // ****************************************************************
  assign S_AXI_AWREADY = ~aw_full_q & ~b_valid_q;
  assign S_AXI_WREADY  = ~w_full_q & ~b_valid_q;
  assign S_AXI_BVALID  = b_valid_q;
  assign S_AXI_BRESP   = b_resp_q;
  assign wr_go         = aw_full_q & w_full_q & ~b_valid_q;

  // Clear mask for the cause record, only on a taken write.
  always @* begin
    cause_clr = 4'h0;
    if (wr_go && aw_addr_q == `MCSW_CAUSE_ADDR && w_strb_q[0]) begin
      cause_clr = w_data_q[3:0];
    end
  end

  // Holds address and data in either order, then answers once both are in.
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= {ADDR_W{1'b0}};
      w_full_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      b_valid_q <= 1'b0;
      b_resp_q  <= RESP_OKAY;
      ctrl_q    <= `MCSW_CTRL_RESET;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        b_valid_q <= 1'b1;
        b_resp_q  <= RESP_OKAY;
        case (aw_addr_q)
          `MCSW_CTRL_ADDR: begin
            ctrl_q <= lane_merge(ctrl_q, w_data_q, w_strb_q) & 32'h0000_0003;
          end
          `MCSW_CAUSE_ADDR: begin
            b_resp_q <= RESP_OKAY;
          end
          `MCSW_WORD_LO_ADDR, `MCSW_WORD_HI_ADDR, `MCSW_EVENT_ADDR,
          `MCSW_INFO_ADDR, `MCSW_ENTRY_ADDR: begin
            b_resp_q <= RESP_OKAY;
          end
          default: begin
            b_resp_q <= RESP_SLVERR;
          end
        endcase
      end else if (b_valid_q && S_AXI_BREADY) begin
        b_valid_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel.
  // ****************************************************************
  assign S_AXI_ARREADY = ~r_valid_q;
  assign S_AXI_RVALID  = r_valid_q;
  assign S_AXI_RDATA   = r_data_q;
  assign S_AXI_RRESP   = r_resp_q;

  // Reads have no side effects; the answer comes one cycle after the address.
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r_valid_q <= 1'b0;
      r_data_q  <= 32'h0000_0000;
      r_resp_q  <= RESP_OKAY;
    end else begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        r_valid_q <= 1'b1;
        r_resp_q  <= RESP_OKAY;
        case (S_AXI_ARADDR)
          `MCSW_WORD_LO_ADDR: r_data_q <= word_q[31:0];
          `MCSW_WORD_HI_ADDR: r_data_q <= word_q[63:32];
          `MCSW_CTRL_ADDR:    r_data_q <= ctrl_q;
          `MCSW_EVENT_ADDR:   r_data_q <= {31'h0000_0000, valid_q};
          `MCSW_INFO_ADDR:    r_data_q <= {16'h0000, word_q[47:32]};
          `MCSW_ENTRY_ADDR:   r_data_q <= {24'h00_0000, reason_q};
          `MCSW_CAUSE_ADDR:   r_data_q <= {28'h000_0000, cause_q};
          default: begin
            r_data_q <= 32'h0000_0000;
            r_resp_q <= RESP_SLVERR;
          end
        endcase
      end else if (r_valid_q && S_AXI_RREADY) begin
        r_valid_q <= 1'b0;
      end
    end
  end

endmodule

// >>> mcsw_props.sv
// Concurrent checks on the state word and entry reason outputs.
`timescale 1ns/100ps
module mcsw_props (
  input wire        REF_CLK,
  input wire        RESET_N,
  input wire        EVT_MCHECK,
  input wire        EVT_INIT,
  input wire        EVT_RESET,
  input wire        EVT_RECOVER,
  input wire        PRECISE_IP_FLAG,
  input wire        EXACT_SAVE_AREA_FLAG,
  input wire        VOLATILE_STATE_OK,
  input wire        REGISTER_STACK_OK,
  input wire        ERROR_FIXED,
  input wire        ANTICIPATED_ERROR,
  input wire [10:0] RESOURCE_OK,
  input wire        GENERAL_REGS_OK,
  input wire [15:0] DSIZE_BYTES,
  input wire [4:0]  FAULT_CATEGORY,
  input wire [63:0] MACHINE_CHECK_STATE_WORD,
  input wire [7:0]  PLATFORM_FIRMWARE_ENTRY
);
  wire [63:0] wd = MACHINE_CHECK_STATE_WORD;  // Short alias of the word.
  wire [7:0]  rc = PLATFORM_FIRMWARE_ENTRY;   // Short alias of the reason.
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  // Event decode in the order of precedence: reset, restart, check, recovery.
  sequence s_init; EVT_INIT && !EVT_RESET; endsequence
  sequence s_mck; EVT_MCHECK && !EVT_INIT && !EVT_RESET; endsequence
  sequence s_load; (EVT_MCHECK || EVT_INIT) && !EVT_RESET; endsequence
  sequence s_rec; EVT_RECOVER && !EVT_MCHECK && !EVT_INIT && !EVT_RESET; endsequence
  sequence s_quiet; !(EVT_INIT || EVT_MCHECK || EVT_RESET || EVT_RECOVER); endsequence
  AST_EXACT_IMPLIES_IP: assert property (wd[14] |-> wd[13])
    else $error("exact save flag set without ip flag");
  AST_RSVD_ZERO: assert property (wd[58:48] == 11'h000)
    else $error("reserved word bits not zero");
  AST_REASON_LEGAL: assert property (rc <= 8'h03)
    else $error("reserved entry reason code");
  AST_INIT_FIELDS: assert property (s_init |=> wd[16] && wd[14:13] == 2'b00
    && wd[19:18] == 2'b00 && wd[63:59] == 5'h00 && rc == 8'h02)
    else $error("restart fields wrong");
  AST_MCHECK_CAUSE: assert property (s_mck |=> !wd[16] && rc == 8'h01
    && wd[63:59] == $past(FAULT_CATEGORY)) else $error("check cause or categories wrong");
  AST_MCHECK_FLAGS: assert property (s_mck |=>
    wd[13] == ($past(PRECISE_IP_FLAG) | $past(EXACT_SAVE_AREA_FLAG))
    && wd[14] == $past(EXACT_SAVE_AREA_FLAG)
    && wd[19:18] == {$past(ANTICIPATED_ERROR), $past(ERROR_FIXED)})
    else $error("check precision or outcome flags wrong");
  AST_STATE_COPY: assert property (s_load |=> wd[15] == $past(VOLATILE_STATE_OK)
    && wd[17] == $past(REGISTER_STACK_OK) && wd[47:32] == $past(DSIZE_BYTES)
    && wd[31:20] == {$past(GENERAL_REGS_OK), $past(RESOURCE_OK)})
    else $error("validity flags or size wrong");
  AST_RECOVER_KEEPS: assert property (s_rec |=> rc == 8'h03 && $stable(wd))
    else $error("recovery entry wrong");
  AST_RESET_CLEARS: assert property (EVT_RESET |=> wd == 64'h0 && rc == 8'h00)
    else $error("reset entry did not clear");
  AST_QUIET_HOLDS: assert property (s_quiet |=> $stable(wd) && $stable(rc))
    else $error("outputs moved without an event");
endmodule
bind mcsw_state_word mcsw_props mcsw_props_i (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
  .EVT_MCHECK(EVT_MCHECK), .EVT_INIT(EVT_INIT), .EVT_RESET(EVT_RESET),
  .EVT_RECOVER(EVT_RECOVER), .PRECISE_IP_FLAG(PRECISE_IP_FLAG),
  .EXACT_SAVE_AREA_FLAG(EXACT_SAVE_AREA_FLAG), .VOLATILE_STATE_OK(VOLATILE_STATE_OK),
  .REGISTER_STACK_OK(REGISTER_STACK_OK), .ERROR_FIXED(ERROR_FIXED),
  .ANTICIPATED_ERROR(ANTICIPATED_ERROR), .RESOURCE_OK(RESOURCE_OK),
  .GENERAL_REGS_OK(GENERAL_REGS_OK), .DSIZE_BYTES(DSIZE_BYTES),
  .FAULT_CATEGORY(FAULT_CATEGORY), .MACHINE_CHECK_STATE_WORD(MACHINE_CHECK_STATE_WORD),
  .PLATFORM_FIRMWARE_ENTRY(PLATFORM_FIRMWARE_ENTRY));

// >>> mcsw_fw_model.sv
// Firmware handler model: an AXI4-Lite master that reads and writes the block.
`timescale 1ns/100ps
module mcsw_fw_model (
  input  wire         clk,
  output logic [7:0]  awaddr,
  output logic        awvalid,
  input  wire         awready,
  output logic [31:0] wdata,
  output logic [3:0]  wstrb,
  output logic        wvalid,
  input  wire         wready,
  input  wire  [1:0]  bresp,
  input  wire         bvalid,
  output logic        bready,
  output logic [7:0]  araddr,
  output logic        arvalid,
  input  wire         arready,
  input  wire  [31:0] rdata,
  input  wire  [1:0]  rresp,
  input  wire         rvalid,
  output logic        rready
);
  // Idle bus at time zero.
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // One write; released payload is inverted so stale data never looks valid.
  task wr(input logic [7:0] a, input logic [31:0] d, input int slow, output logic [1:0] r);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && awready) begin pa = 1'b0; awvalid <= 1'b0; awaddr <= ~a; end
      if (pw && wready) begin pw = 1'b0; wvalid <= 1'b0; wdata <= ~d; end
    end
    repeat (slow) @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  // One read, with an optional stall before the data is accepted.
  task rd(input logic [7:0] a, input int slow, output logic [31:0] d, output logic [1:0] r);
    araddr <= a; arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0; araddr <= ~a;
    repeat (slow) @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    d = rdata; r = rresp; rready <= 1'b0;
  endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the state word block against a behavioural model.
`timescale 1ns/100ps
`include "mcsw_regs.vh"
module tb_top;
  logic REF_CLK = 1'b0;    // 40 MHz clock.
  logic RESET_N = 1'b0;    // Active low reset.
  logic [3:0]  ev = 4'h0;  // Events: reset, check, restart, recovery.
  logic [38:0] st = '0;    // Random flags, size and categories.
  wire [63:0] word; wire [7:0] reason; wire vld;
  wire [7:0] awaddr, araddr; wire [31:0] wdata, rdata; wire [3:0] wstrb;
  wire [1:0] bresp, rresp;
  wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int seed = 72; int fail_count = 0; int n_compared = 0;
  logic [63:0] mw = '0; logic [7:0] mr = '0; logic mv = 1'b0;  // Model state.
  logic [3:0] mc = 4'h0;  // Model of the sticky cause record.
  logic [31:0] d; logic [1:0] r;
  always #12.5 REF_CLK = ~REF_CLK;
  mcsw_state_word mcsw_state_word_i (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
    .EVT_RESET(ev[0]), .EVT_MCHECK(ev[1]), .EVT_INIT(ev[2]), .EVT_RECOVER(ev[3]),
    .PRECISE_IP_FLAG(st[38]), .EXACT_SAVE_AREA_FLAG(st[37]), .VOLATILE_STATE_OK(st[36]),
    .REGISTER_STACK_OK(st[35]), .ERROR_FIXED(st[34]), .ANTICIPATED_ERROR(st[33]),
    .RESOURCE_OK(st[32:22]), .GENERAL_REGS_OK(st[21]), .DSIZE_BYTES(st[20:5]),
    .FAULT_CATEGORY(st[4:0]), .MACHINE_CHECK_STATE_WORD(word),
    .PLATFORM_FIRMWARE_ENTRY(reason), .WORD_VALID(vld), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  mcsw_fw_model fw_i (.clk(REF_CLK), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // Compares an output value with the model.
  task chk_out(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e) begin fail_count++; $display("wrong value at %0t: out %h exp %h", $time, g, e); end
  endtask
  // Compares bus data and response with the model.
  task chk_bus(input logic [31:0] g, e, input logic [1:0] gr, er);
    n_compared++;
    if (g !== e || gr !== er) begin
      fail_count++;
      $display("wrong value at %0t: bus %h/%h exp %h/%h", $time, g, gr, e, er);
    end
  endtask
  // Model of one event taken with the current inputs, in order of precedence.
  task model(input logic [3:0] e);
    logic [63:0] b;
    b = '0; b[13] = st[38] | st[37]; b[14] = st[37]; b[15] = st[36]; b[17] = st[35];
    b[19:18] = {st[33], st[34]}; b[31:20] = {st[21], st[32:22]};
    b[47:32] = st[20:5]; b[63:59] = st[4:0];
    if (e != 4'h0) mv = 1'b1;
    mc = mc | e;
    if (e[0]) begin mw = '0; mr = `MCSW_REASON_RESET; end
    else if (e[2]) begin
      mw = b; mw[14:13] = 2'b00; mw[16] = 1'b1; mw[19:18] = 2'b00; mw[63:59] = 5'h00;
      mr = `MCSW_REASON_INIT;
    end
    else if (e[1]) begin mw = b; mr = `MCSW_REASON_MCHECK; end
    else if (e[3]) mr = `MCSW_REASON_RECOVER;
  endtask
  // Checks the word, reason and valid outputs against the model.
  task chk_all;
    chk_out(word, mw);
    chk_out({56'h0, reason}, {56'h0, mr});
    chk_out({63'h0, vld}, {63'h0, mv});
  endtask
  // Drives one event pulse with fresh random inputs.
  task evt_step(input logic [3:0] e);
    @(posedge REF_CLK);
    ev <= e;
    st <= 39'({$random(seed), $random(seed)});
    @(posedge REF_CLK);
    ev <= 4'h0;
    @(negedge REF_CLK);
    model(e);
    chk_all;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge REF_CLK);
    fw_i.rd(a, $unsigned($random(seed)) % 4, d, r);
    chk_bus(d, e, r, er);
  endtask
  task wr_chk(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge REF_CLK);
    fw_i.wr(a, v, $unsigned($random(seed)) % 4, r);
    chk_bus(32'h0, 32'h0, r, er);
  endtask
  task wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    repeat (16) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    @(negedge REF_CLK);
    chk_all;
    evt_step(4'h2); evt_step(4'h4); evt_step(4'h8); evt_step(4'h1);
    repeat (300) evt_step(4'($random(seed)));
    @(posedge REF_CLK);
    RESET_N <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    mw = '0; mr = '0; mv = 1'b0;
    mc = 4'h0;
    @(negedge REF_CLK);
    chk_all;
    evt_step(4'h2);
    rd_chk(`MCSW_WORD_LO_ADDR, mw[31:0], 2'b00);
    rd_chk(`MCSW_WORD_HI_ADDR, mw[63:32], 2'b00);
    rd_chk(`MCSW_ENTRY_ADDR, {24'h0, mr}, 2'b00);
    rd_chk(8'h1c, 32'h0, 2'b10);
    wr_chk(`MCSW_WORD_LO_ADDR, 32'hffffffff, 2'b00);
    rd_chk(`MCSW_WORD_LO_ADDR, mw[31:0], 2'b00);
    wr_chk(`MCSW_CTRL_ADDR, 32'hfffffffc, 2'b00);
    rd_chk(`MCSW_CTRL_ADDR, 32'h0, 2'b00);
    wr_chk(8'h1c, 32'h1, 2'b10);
    // Valid flag, size copy and sticky cause record read back over the bus.
    rd_chk(`MCSW_EVENT_ADDR, {31'h0, mv}, 2'b00);
    rd_chk(`MCSW_INFO_ADDR, {16'h0, mw[47:32]}, 2'b00);
    rd_chk(`MCSW_CAUSE_ADDR, {28'h0, mc}, 2'b00);
    wr_chk(`MCSW_CAUSE_ADDR, 32'hf, 2'b00);
    mc = 4'h0;
    rd_chk(`MCSW_CAUSE_ADDR, 32'h0, 2'b00);
    // Control bits hold their value; cleared again before the next event.
    wr_chk(`MCSW_CTRL_ADDR, 32'h3, 2'b00);
    rd_chk(`MCSW_CTRL_ADDR, 32'h3, 2'b00);
    wr_chk(`MCSW_CTRL_ADDR, 32'h0, 2'b00);
    evt_step(4'h2);
    wrap_up;
  end
  // Cuts a hang short.
  initial begin
    #500000;
    fail_count++;
    wrap_up;
  end
endmodule
